// ### src/hcfg_defines.svh
// Offsets, field positions, reset values and timing counts of the host configuration block.
// Assumes a 50 MHz system clock and 32-bit AXI4-Lite register access.
`ifndef HCFG_DEFINES_SVH
`define HCFG_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_RESET 8'h00
`define OFS_MCFG 8'h04
`define OFS_LARGE 8'h08
`define OFS_SMALL 8'h0C
`define OFS_BURST 8'h10
`define OFS_BRIDGE 8'h14
`define OFS_STATUS 8'h18
`define OFS_TXPORT 8'h1C
`define OFS_DATA 8'h20
`define OFS_LOWWM 8'h24
`define OFS_DATA_EOF 8'h28
`define OFS_CHSEL 8'h2C
`define OFS_CHDATA 8'h30
// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define RST_BIT 0
`define MC_RXDMA 0
`define MC_TXDMA 1
`define MC_DBURST 2
`define MC_DB16 3
`define MC_POL 5:4
`define LB_BRIDGE 0
`define TP_ALLOW 0
`define REG_ZERO 16'h0000
`define BUF_SIZE_MAX 16'h1FFC
`define DATA_BURST_MAX 16'h0100
`define DESC_BURST_ONE 5'h01
`define DESC_BURST_SHORT 5'h08
`define DESC_BURST_LONG 5'h10
`define CHAN_MAX 16'h0100
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define STARTUP_TIME_NS 625000
`define STARTUP_CYCLES ((`STARTUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### src/hcfg_pkg.sv
// Types shared by the host configuration block.
// Assumes the constants of hcfg_defines.svh.
package hcfg_pkg;
    typedef enum logic [1:0] {
        POL_LARGE = 2'b00,
        POL_SMALL = 2'b01,
        POL_SMALL_FIRST = 2'b10
    } rx_policy_t;

    typedef struct packed {
        logic rxDmaOn;
        logic txDmaOn;
        rx_policy_t policy;
        logic [12:0] largeSize;
        logic [12:0] smallSize;
        logic [4:0] descBurst;
        logic [8:0] dataBurstMax;
    } dma_cfg_t;

    typedef struct packed {
        logic [31:0] addr;
        logic useLarge;
    } free_desc_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [12:0] len;
    } place_t;

    typedef struct packed {
        logic awHave;
        logic wHave;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [1:0] rResp;
        logic [31:0] rData;
        logic softRst;
        logic [15:0] mcfg;
        logic [15:0] largeSz;
        logic [15:0] smallSz;
        logic [15:0] burstMax;
        logic [15:0] bridge;
        logic [15:0] txPort;
        logic [15:0] lowWm;
        logic [15:0] chanSel;
        logic [31:0] upCnt;
        logic [3:0] eofCnt;
        logic placeValid;
        place_t place;
    } state_t;
endpackage : hcfg_pkg

// ### src/host_config_init_and_dma_setup.sv
// Host configuration block with its transmit word FIFO.
// Assumes an AXI4-Lite master on the register side, a framing engine on the word side.
//
// Operation
// - Config registers hold 16 bits, any strobe writes the whole word
// - Access completes for any nonzero strobes; zero strobes write nothing
// - Hard reset clears every config register to zero; soft reset clears all but bridge mode
// - Bridge mode register survives soft reset, cleared only by hard reset
// - Indirect storage is never touched by any reset
// - Large and small receive buffer sizes each at most 8188 bytes
// - Receive storage: large only, small only, or small then large
// - Descriptor bursting moves 8 or 16 descriptors per transaction
// - One data burst never exceeds 256 dwords
// - A free-queue descriptor alone gives the full data placement
// - Transmit FIFO fills fully; words leave above low watermark or at end of frame
// - Local bus acts as bridge master or configuration slave
// - Channels numbered 1 to 256 across at most 16 ports
`timescale 1ns/10ps
`include "hcfg_defines.svh"

// ----------------------------------------
// Word FIFO
// ----------------------------------------
module word_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign inReady = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData = mem[rdPtr_r];
    assign count = count_r;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage needs no reset; pointers define what is valid
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end
endmodule : word_fifo

// ----------------------------------------
// Top
// ----------------------------------------
module host_config_init_and_dma_setup
    import hcfg_pkg::*;
#(
    parameter int STARTUP_CYCLES = `STARTUP_CYCLES,
    parameter int FIFO_DEPTH = 8,
    parameter logic [14:0] DEVICE_ID = 15'h0123 // Arbitrary value
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output dma_cfg_t dmaCfg,
    output logic bridgeMode,
    output logic portsReady,
    input wire logic freeDescValid,
    input free_desc_t freeDesc,
    output logic placeValid,
    output place_t place,
    output logic txWordValid,
    input wire logic txWordReady,
    output logic [31:0] txWordData,
    output logic txWordEof
);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;
    state_t s;
    state_t n;
    logic [1:0] chanMem [0:255];
    logic [31:0] rdMux;
    logic rdErr;
    logic pushValid;
    logic pushReady;
    logic popValid;
    logic [32:0] popData;
    logic [CW-1:0] fifoCount;
    logic txGate;
    logic chanWr;
    logic chanOk;

    // ----------------------------------------
    // Bus handshakes
    // ----------------------------------------
    assign awready = !s.awHave && !s.bValid;
    assign wready = !s.wHave && !s.bValid;
    assign arready = !s.rValid;
    assign bvalid = s.bValid;
    assign bresp = s.bResp;
    assign rvalid = s.rValid;
    assign rresp = s.rResp;
    assign rdata = s.rData;

    // Channel numbers start at 1; zero and above 256 are ignored
    assign chanOk = (s.chanSel != 16'h0000) && (s.chanSel <= `CHAN_MAX);

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    always_comb begin
        rdMux = 32'h0000_0000;
        rdErr = 1'b0;
        case (araddr)
            `OFS_RESET: rdMux = {16'h0000, DEVICE_ID, 1'b0};
            `OFS_MCFG: rdMux = {16'h0000, s.mcfg};
            `OFS_LARGE: rdMux = {16'h0000, s.largeSz};
            `OFS_SMALL: rdMux = {16'h0000, s.smallSz};
            `OFS_BURST: rdMux = {16'h0000, s.burstMax};
            `OFS_BRIDGE: rdMux = {16'h0000, s.bridge};
            `OFS_STATUS: rdMux = {26'h000_0000, !pushReady, fifoCount[3:0], portsReady};
            `OFS_TXPORT: rdMux = {16'h0000, s.txPort};
            `OFS_LOWWM: rdMux = {16'h0000, s.lowWm};
            `OFS_CHSEL: rdMux = {16'h0000, s.chanSel};
            `OFS_CHDATA: rdMux = chanOk ? {30'h0000_0000, chanMem[s.chanSel[7:0] - 8'h01]}
                                        : 32'h0000_0000;
            default: rdErr = 1'b1;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = s;
        pushValid = 1'b0;
        chanWr = 1'b0;
        if (s.rValid && rready) begin
            n.rValid = 1'b0;
        end
        if (arvalid && arready) begin
            n.rValid = 1'b1;
            n.rData = rdMux;
            n.rResp = rdErr ? `RESP_SLVERR : `RESP_OKAY;
        end
        if (s.bValid && bready) begin
            n.bValid = 1'b0;
        end
        if (awvalid && awready) begin
            n.awHave = 1'b1;
            n.awAddr = awaddr;
        end
        if (wvalid && wready) begin
            n.wHave = 1'b1;
            n.wData = wdata;
            n.wStrb = wstrb;
        end
        if (s.upCnt < 32'(STARTUP_CYCLES)) begin
            n.upCnt = s.upCnt + 32'h0000_0001;
        end
        // Soft reset spares the bridge register and all indirect storage
        if (s.softRst) begin
            n.softRst = 1'b0;
            n.mcfg = `REG_ZERO;
            n.largeSz = `REG_ZERO;
            n.smallSz = `REG_ZERO;
            n.burstMax = `REG_ZERO;
            n.txPort = `REG_ZERO;
            n.lowWm = `REG_ZERO;
            n.chanSel = `REG_ZERO;
            n.upCnt = 32'h0000_0000;
        end
        // Data writes to a full FIFO wait here; that stalls the bus master
        if (s.awHave && s.wHave && !s.bValid && (pushReady || s.wStrb == 4'h0 ||
                (s.awAddr != `OFS_DATA && s.awAddr != `OFS_DATA_EOF))) begin
            n.awHave = 1'b0;
            n.wHave = 1'b0;
            n.bValid = 1'b1;
            n.bResp = `RESP_OKAY;
            if (s.wStrb != 4'h0) begin
                case (s.awAddr)
                    `OFS_RESET: n.softRst = s.wData[`RST_BIT];
                    `OFS_MCFG: n.mcfg = s.wData[15:0];
                    `OFS_LARGE: n.largeSz = (s.wData[15:0] > `BUF_SIZE_MAX) ?
                                            `BUF_SIZE_MAX : s.wData[15:0];
                    `OFS_SMALL: n.smallSz = (s.wData[15:0] > `BUF_SIZE_MAX) ?
                                            `BUF_SIZE_MAX : s.wData[15:0];
                    `OFS_BURST: n.burstMax = (s.wData[15:0] > `DATA_BURST_MAX) ?
                                             `DATA_BURST_MAX : s.wData[15:0];
                    `OFS_BRIDGE: n.bridge = s.wData[15:0];
                    `OFS_STATUS: n.bResp = `RESP_OKAY;
                    `OFS_TXPORT: n.txPort = s.wData[15:0];
                    `OFS_LOWWM: n.lowWm = s.wData[15:0];
                    `OFS_CHSEL: n.chanSel = s.wData[15:0];
                    `OFS_CHDATA: chanWr = chanOk;
                    `OFS_DATA, `OFS_DATA_EOF: pushValid = 1'b1;
                    default: n.bResp = `RESP_SLVERR;
                endcase
            end
        end
        // End-of-frame words in the FIFO release it below the watermark
        n.eofCnt = s.eofCnt + 4'((pushValid && s.awAddr == `OFS_DATA_EOF) ? 1 : 0)
                            - 4'((popValid && txGate && txWordReady && popData[32]) ? 1 : 0);
        // Placement comes from the descriptor alone, no pointer chasing
        n.placeValid = freeDescValid;
        if (freeDescValid) begin
            n.place.addr = freeDesc.addr;
            case (dmaCfg.policy)
                POL_LARGE: n.place.len = dmaCfg.largeSize;
                POL_SMALL: n.place.len = dmaCfg.smallSize;
                POL_SMALL_FIRST: n.place.len = freeDesc.useLarge ?
                                               dmaCfg.largeSize : dmaCfg.smallSize;
                default: n.place.len = dmaCfg.largeSize;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Indirect channel storage: no reset of either kind reaches it
    always_ff @(posedge clk_sys) begin
        if (chanWr) begin
            chanMem[s.chanSel[7:0] - 8'h01] <= s.wData[1:0];
        end
    end

    // ----------------------------------------
    // Configuration outputs
    // ----------------------------------------
    assign dmaCfg.rxDmaOn = s.mcfg[`MC_RXDMA];
    assign dmaCfg.txDmaOn = s.mcfg[`MC_TXDMA];
    assign dmaCfg.policy = rx_policy_t'(s.mcfg[`MC_POL]);
    assign dmaCfg.largeSize = s.largeSz[12:0];
    assign dmaCfg.smallSize = s.smallSz[12:0];
    assign dmaCfg.descBurst = !s.mcfg[`MC_DBURST] ? `DESC_BURST_ONE :
                              s.mcfg[`MC_DB16] ? `DESC_BURST_LONG : `DESC_BURST_SHORT;
    assign dmaCfg.dataBurstMax = s.burstMax[8:0];
    assign bridgeMode = s.bridge[`LB_BRIDGE];
    assign portsReady = (s.upCnt >= 32'(STARTUP_CYCLES));
    assign placeValid = s.placeValid;
    assign place = s.place;

    // ----------------------------------------
    // Transmit word path
    // ----------------------------------------
    word_fifo #(
        .WIDTH(33),
        .DEPTH(FIFO_DEPTH)
    ) txFifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .inValid(pushValid),
        .inReady(pushReady),
        .inData({s.awAddr == `OFS_DATA_EOF, s.wData}),
        .outValid(popValid),
        .outReady(txGate && txWordReady),
        .outData(popData),
        .count(fifoCount)
    );

    // Words only leave once transmit DMA and data allow are both set
    assign txGate = s.mcfg[`MC_TXDMA] && s.txPort[`TP_ALLOW] &&
                    ((16'(fifoCount) > s.lowWm) || s.eofCnt != 4'h0);
    assign txWordValid = popValid && txGate;
    assign txWordData = popData[31:0];
    assign txWordEof = popData[32];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_zero_strobe: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s.awHave && s.wHave && !s.bValid && s.wStrb == 4'h0) |=> $stable(s.mcfg)
            && $stable(fifoCount))
        else $error("Write without strobes changed state");
    a_soft_clears: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s.softRst |=> (s.mcfg == 16'h0000 && s.largeSz == 16'h0000 && !portsReady))
        else $error("Soft reset left a register set");
    a_bridge_kept: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s.softRst |=> $stable(s.bridge))
        else $error("Soft reset touched bridge mode");
    a_startup_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(portsReady) |-> $past(s.upCnt) == 32'(STARTUP_CYCLES - 1))
        else $error("Ports ready too early");
    a_buffer_size: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s.largeSz <= 16'h1FFC && s.smallSz <= 16'h1FFC)
        else $error("Buffer size above 8188");
    a_desc_burst: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s.mcfg[`MC_DBURST] |-> (dmaCfg.descBurst == 5'h08 || dmaCfg.descBurst == 5'h10))
        else $error("Descriptor burst not 8 or 16");
    a_data_burst: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s.burstMax <= 16'h0100)
        else $error("Data burst above 256 dwords");
    a_tx_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
        txWordValid |-> (16'(fifoCount) > s.lowWm || s.eofCnt != 4'h0) && s.txPort[0])
        else $error("Word left below watermark");
    a_write_answer: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s.awHave && s.wHave && !s.bValid && s.awAddr != `OFS_DATA
            && s.awAddr != `OFS_DATA_EOF) |=> s.bValid)
        else $error("Write not answered in one cycle");
endmodule : host_config_init_and_dma_setup

// ### test/frame_sink.sv
// Framing engine stand-in that takes transmit words and records them.
// Assumes the block's word stream: valid and data held until taken.
`timescale 1ns/10ps
module frame_sink (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic stall,
    input wire logic txWordValid,
    input wire logic [31:0] txWordData,
    input wire logic txWordEof,
    output logic txWordReady
);
    // ------
    // Sink
    // ------
    logic [32:0] words [0:15];
    int n;
    // Stall on command only, so the FIFO can be driven to full
    // The stall input lets the bench hold the stream back, as a rate-capped port would
    assign txWordReady = !stall;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            n <= 0;
        end else if (txWordValid && txWordReady && n < 16) begin
            words[n] <= {txWordEof, txWordData};
            n <= n + 1;
        end
    end
endmodule : frame_sink

// ### test/tb.sv
// Register, descriptor and transmit stream bench of the host configuration block.
// Assumes the block's AXI4-Lite map and a 20 cycle start-up count.
`timescale 1ns/10ps
`include "hcfg_defines.svh"
module tb import hcfg_pkg::*; ();
    logic clk_sys, reset_n, stall;
    logic [7:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready, freeDescValid, txWordReady;
    logic awready, wready, bvalid, arready, rvalid, bridgeMode, portsReady, placeValid;
    logic txWordValid, txWordEof;
    logic [31:0] wdata, rdata, txWordData;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    dma_cfg_t dmaCfg;
    free_desc_t freeDesc;
    place_t place;
    int n_fail, tests_run;
    logic [7:0] cfgOfs [7] = '{`OFS_MCFG, `OFS_LARGE, `OFS_SMALL, `OFS_BURST,
        `OFS_TXPORT, `OFS_LOWWM, `OFS_CHSEL};

    host_config_init_and_dma_setup #(.STARTUP_CYCLES(20), .FIFO_DEPTH(8)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .dmaCfg(dmaCfg), .bridgeMode(bridgeMode),
        .portsReady(portsReady), .freeDescValid(freeDescValid), .freeDesc(freeDesc),
        .placeValid(placeValid), .place(place), .txWordValid(txWordValid),
        .txWordReady(txWordReady), .txWordData(txWordData), .txWordEof(txWordEof));
    frame_sink sink (.clk_sys(clk_sys), .reset_n(reset_n), .stall(stall),
        .txWordValid(txWordValid), .txWordData(txWordData), .txWordEof(txWordEof),
        .txWordReady(txWordReady));

    // ------
    // Tasks
    // ------
    task automatic stop_test;
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // A wait that runs out ends the run at once
    task automatic hang;
        n_fail++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, 1'h0, 1'h1);
        stop_test();
    endtask : hang

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        bit ad, wd, bd;
        ad = 0;
        wd = 0;
        bd = 0;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (int k = 0; k < 300 && !bd; k++) begin
            @(posedge clk_sys);
            if (ad && wd && bvalid) begin
                bd = 1;
                bready <= 1'h0;
                chk({30'h0, bresp}, {30'h0, `RESP_OKAY});
            end
            if (!ad && awready) begin
                ad = 1;
                awvalid <= 1'h0;
            end
            if (!wd && wready) begin
                wd = 1;
                wvalid <= 1'h0;
            end
        end
        if (!bd) hang();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        bit ad, rdone;
        ad = 0;
        rdone = 0;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (int k = 0; k < 300 && !rdone; k++) begin
            @(posedge clk_sys);
            if (ad && rvalid) begin
                rdone = 1;
                rready <= 1'h0;
                chk(rdata, e);
                chk({30'h0, rresp}, {30'h0, er});
            end
            if (!ad && arready) begin
                ad = 1;
                arvalid <= 1'h0;
            end
        end
        if (!rdone) hang();
    endtask : rd

    task automatic desc(input logic [1:0] pol, input logic big, input logic [12:0] len);
        wr(`OFS_MCFG, {26'h0, pol, 4'h0}, 4'hF);
        @(posedge clk_sys);
        freeDescValid <= 1'h1;
        freeDesc <= '{addr: 32'hCAFE_0010, useLarge: big};
        @(posedge clk_sys);
        freeDescValid <= 1'h0;
        @(posedge clk_sys);
        chk({31'h0, placeValid}, 32'h1);
        chk(place.addr, 32'hCAFE_0010);
        chk({19'h0, place.len}, {19'h0, len});
    endtask : desc

    task automatic wait_n(input int t);
        for (int k = 0; k < 200 && sink.n < t; k++) begin
            @(posedge clk_sys);
        end
        if (sink.n < t) hang();
    endtask : wait_n

    // ------
    // Sequence
    // ------
    initial begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        {reset_n, stall, awaddr, araddr, awvalid, wvalid, bready, arvalid} = '0;
        {rready, freeDescValid, wdata, wstrb, freeDesc} = '0;
        n_fail = 0;
        tests_run = 0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'h1;
        @(posedge clk_sys);
        chk({31'h0, portsReady}, 32'h0);
        foreach (cfgOfs[i]) rd(cfgOfs[i], 32'h0, `RESP_OKAY);
        rd(`OFS_BRIDGE, 32'h0, `RESP_OKAY);
        rd(8'h3C, 32'h0, `RESP_SLVERR);
        chk({31'h0, portsReady}, 32'h1);
        wr(`OFS_CHSEL, 32'h0000_0001, 4'hF);
        wr(`OFS_CHDATA, 32'h0000_0000, 4'hF);
        rd(`OFS_CHDATA, 32'h0, `RESP_OKAY);
        wr(`OFS_MCFG, 32'h0000_000F, 4'h8);
        rd(`OFS_MCFG, 32'h0000_000F, `RESP_OKAY);
        chk({30'h0, dmaCfg.rxDmaOn, dmaCfg.txDmaOn}, 32'h3);
        chk({27'h0, dmaCfg.descBurst}, {27'h0, `DESC_BURST_LONG});
        wr(`OFS_MCFG, 32'h0000_0001, 4'h0);
        rd(`OFS_MCFG, 32'h0000_000F, `RESP_OKAY);
        wr(`OFS_MCFG, 32'h0000_0004, 4'hF);
        chk({27'h0, dmaCfg.descBurst}, {27'h0, `DESC_BURST_SHORT});
        wr(`OFS_LARGE, 32'h0000_FFFF, 4'h3);
        rd(`OFS_LARGE, 32'h0000_1FFC, `RESP_OKAY);
        wr(`OFS_SMALL, 32'h0000_1FFC, 4'h1);
        rd(`OFS_SMALL, 32'h0000_1FFC, `RESP_OKAY);
        wr(`OFS_BURST, 32'h0000_0300, 4'hF);
        rd(`OFS_BURST, 32'h0000_0100, `RESP_OKAY);
        chk({23'h0, dmaCfg.dataBurstMax}, 32'h0000_0100);
        wr(`OFS_LARGE, 32'h0000_0400, 4'hF);
        wr(`OFS_SMALL, 32'h0000_0080, 4'hF);
        desc(2'h0, 1'h0, 13'h0400);
        desc(2'h1, 1'h1, 13'h0080);
        desc(2'h2, 1'h0, 13'h0080);
        desc(2'h2, 1'h1, 13'h0400);
        desc(2'h3, 1'h0, 13'h0400);
        chk({27'h0, dmaCfg.descBurst}, {27'h0, `DESC_BURST_ONE});
        // Transmit path: one word stays below the watermark until an end of frame
        wr(`OFS_LOWWM, 32'h0000_0002, 4'hF);
        wr(`OFS_TXPORT, 32'h0000_0001, 4'hF);
        wr(`OFS_MCFG, 32'h0000_0002, 4'hF);
        wr(`OFS_DATA, 32'h1111_1111, 4'hF);
        repeat (5) @(posedge clk_sys);
        chk(32'(sink.n), 32'h0);
        wr(`OFS_DATA_EOF, 32'h2222_2222, 4'hF);
        wait_n(2);
        chk(sink.words[0][31:0], 32'h1111_1111);
        chk(sink.words[1][31:0], 32'h2222_2222);
        chk({30'h0, sink.words[0][32], sink.words[1][32]}, 32'h1);
        stall <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            // Last word ends a frame so the tail below the watermark drains too
            wr(i == 7 ? `OFS_DATA_EOF : `OFS_DATA, 32'h5000_0000 + 32'(i), 4'hF);
        end
        rd(`OFS_STATUS, 32'h0000_0031, `RESP_OKAY);
        stall <= 1'h0;
        wait_n(10);
        for (int i = 0; i < 8; i++) begin
            chk(sink.words[i + 2][31:0], 32'h5000_0000 + 32'(i));
        end
        // Soft reset keeps the bridge mode and channel memory
        wr(`OFS_BRIDGE, 32'h0000_0001, 4'hF);
        chk({31'h0, bridgeMode}, 32'h1);
        wr(`OFS_CHSEL, 32'h0000_0100, 4'hF);
        rd(`OFS_CHSEL, 32'h0000_0100, `RESP_OKAY);
        wr(`OFS_CHSEL, 32'h0000_0005, 4'hF);
        wr(`OFS_CHDATA, 32'h0000_0003, 4'hF);
        wr(`OFS_RESET, 32'h0000_0001, 4'hF);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, portsReady}, 32'h0);
        foreach (cfgOfs[i]) rd(cfgOfs[i], 32'h0, `RESP_OKAY);
        rd(`OFS_BRIDGE, 32'h0000_0001, `RESP_OKAY);
        wr(`OFS_CHSEL, 32'h0000_0005, 4'hF);
        rd(`OFS_CHDATA, 32'h0000_0003, `RESP_OKAY);
        reset_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'h1;
        chk({31'h0, bridgeMode}, 32'h0);
        rd(`OFS_BRIDGE, 32'h0, `RESP_OKAY);
        wr(`OFS_CHSEL, 32'h0000_0005, 4'hF);
        rd(`OFS_CHDATA, 32'h0000_0003, `RESP_OKAY);
        stop_test();
    end
endmodule : tb
